// ==== rtl/scc_pkg.sv ====
// scc_pkg: register map, field layout, reset values and types
// How it works
// - four user characters, any byte value, are escaped in PPP transmit.
// - flag 0x7E always escaped; user fields reset to 0x7E.
// - seven-bit slot number per direction picks one of 128 slots.
// - three-bit clock shift per direction shifts slot position after sync.
// - unmasked transmit slot is capacity plus one bits wide.
// - unmasked receive slot is capacity plus one bits wide.
// - transmit mask on: 8-bit slots, capacity ignored, masked slots active.
// - receive mask on: 8-bit slots, capacity ignored, masked slots active.
// - mask bit n enables eight-bit slot n of 32.
// - in mask operation slot number and shift place slot zero.
// - slot settings act only in clock mode 5.
// - baud divider k equals (N+1) times two to the M.
// - timer ticks on transmit clock, or frame sync in mode 5.
// - external mode: start command runs timer; last expiry stops and interrupts.
// - writing value zero halts a running external timer.
// - internal mode in HDLC automode serves protocol time-outs and retries.
// - expiry period is value plus one timer clock periods.
// - restart count gives restarts, up to 6; 7 means periodic.
package scc_pkg;

  // register byte offsets
  localparam logic [11:0] CMD_OFF      = 12'h100;
  localparam logic [11:0] INT_STAT_OFF = 12'h104;
  localparam logic [11:0] INT_MASK_OFF = 12'h108;
  localparam logic [11:0] CTRL_OFF     = 12'h10C;
  localparam logic [11:0] ESC_OFF      = 12'h118;
  localparam logic [11:0] TX_SLOT_OFF  = 12'h11C;
  localparam logic [11:0] RX_SLOT_OFF  = 12'h120;
  localparam logic [11:0] TX_MASK_OFF  = 12'h124;
  localparam logic [11:0] RX_MASK_OFF  = 12'h128;
  localparam logic [11:0] BAUD_OFF     = 12'h12C;
  localparam logic [11:0] TIMER_OFF    = 12'h130;

  // field positions
  localparam int SLOT_NUM_LSB  = 24;
  localparam int SLOT_SH_LSB   = 16;
  localparam int SLOT_PCM_BIT  = 15;
  localparam int BAUD_M_LSB    = 6;
  localparam int TM_SRC_BIT    = 31;
  localparam int TM_MODE_BIT   = 28;
  localparam int TM_CNT_LSB    = 24;
  localparam int CTRL_PPP_BIT  = 4;
  localparam int CTRL_AUTO_BIT = 5;
  localparam int CMD_STI_BIT   = 0;
  localparam int INT_TM_BIT    = 0;
  localparam int INT_FS_BIT    = 1;

  // writable bits and reset values
  localparam logic [31:0] SLOT_WMASK  = 32'h7F07_81FF;
  localparam logic [31:0] BAUD_WMASK  = 32'h0000_03FF;
  localparam logic [31:0] TIMER_WMASK = 32'h97FF_FFFF;
  localparam logic [5:0]  CTRL_WMASK  = 6'h37;
  localparam logic [31:0] ESC_RESET   = 32'h7E7E_7E7E;

  // encodings
  localparam logic [7:0]  FLAG_CHAR      = 8'h7E;
  localparam logic [2:0]  CLOCK_MODE_PCM = 3'h5;
  localparam logic [2:0]  CNT_PERIODIC   = 3'h7;
  localparam logic [11:0] POS_MAX        = 12'hFFF;

  typedef enum logic {TM_IDLE, TM_RUN} scc_tm_state_t;

  typedef struct packed {
    logic [31:0]   esc_chars;
    logic [31:0]   tx_assign;
    logic [31:0]   rx_assign;
    logic [31:0]   tx_mask;
    logic [31:0]   rx_mask;
    logic [31:0]   baud;
    logic [31:0]   timer_cfg;
    logic [5:0]    ctrl;
    logic [1:0]    int_status;
    logic [1:0]    int_mask;
    logic [31:0]   prdata;
    logic [2:0]    s_txclk;
    logic [2:0]    s_fsync;
    logic [2:0]    s_rxd;
    logic          f_txclk;
    logic          f_fsync;
    logic          f_rxd;
    logic [11:0]   pos;
    logic          tx_act;
    logic          rx_act;
    logic          tx_data;
    logic          tx_oe_b;
    logic          tx_req;
    logic          rx_bit;
    logic          rx_valid;
    logic [20:0]   baud_cnt;
    logic          baud_tick;
    scc_tm_state_t tm_state;
    logic [23:0]   tm_count;
    logic [2:0]    tm_restarts;
    logic          tm_timeout;
    logic          esc_valid;
    logic          esc_flag;
  } scc_state_t;

endpackage

// ==== rtl/scc_slot_baud_timer_cfg.sv ====
// scc_slot_baud_timer_cfg: escape, slot, baud and timer logic of a channel
`timescale 1ns/10ps
module scc_slot_baud_timer_cfg
  import scc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // interrupt
  output logic             irq_out,
  // line pins
  input  wire logic        tx_clk_pin_in,
  input  wire logic        frame_sync_input_in,
  input  wire logic        rx_data_pin_in,
  output logic             tx_data_out,
  output logic             tx_data_oe_b_out,
  // bit stream towards the protocol engine
  input  wire logic        tx_bit_in,
  output logic             tx_bit_req_out,
  output logic             rx_bit_out,
  output logic             rx_bit_valid_out,
  // escape check
  input  wire logic        tx_char_valid_in,
  input  wire logic [7:0]  tx_char_in,
  output logic             esc_valid_out,
  output logic             esc_flag_out,
  // protocol timer
  input  wire logic        proto_timer_start_in,
  input  wire logic        proto_timer_stop_in,
  output logic             timer_timeout_out,
  output logic             timer_running_out,
  // baud generator
  output logic             baud_tick_out
);

  scc_state_t st;
  scc_state_t next_st;

  logic        setup;
  logic        wr;
  logic        rd;
  logic        mode5;
  logic        tm_internal;
  logic        txclk_rise;
  logic        fs_rise;
  logic        rxd_now;
  logic        sti_wr;
  logic        zero_wr;
  logic [11:0] tx_start;
  logic [11:0] rx_start;
  logic [20:0] baud_k;

  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a == CMD_OFF) || (a == INT_STAT_OFF) ||
                  (a == INT_MASK_OFF) || (a == CTRL_OFF) ||
                  (a == ESC_OFF) || (a == TX_SLOT_OFF) ||
                  (a == RX_SLOT_OFF) || (a == TX_MASK_OFF) ||
                  (a == RX_MASK_OFF) || (a == BAUD_OFF) ||
                  (a == TIMER_OFF);
  endfunction

  // first bit of the assigned slot relative to frame sync
  function automatic logic [11:0] slot_start(input logic [31:0] cfg);
    slot_start = {2'b00, cfg[SLOT_NUM_LSB+:7], 3'b000} +
                 {9'h000, cfg[SLOT_SH_LSB+:3]};
  endfunction

  // whether bit position p lies in an active slot
  function automatic logic slot_hit(input logic [11:0] p,
                                    input logic [31:0] cfg,
                                    input logic [31:0] msk);
    logic [11:0] start;
    logic [11:0] rel;
    start = slot_start(cfg);
    rel   = p - start;
    if (p < start) begin
      slot_hit = 1'b0;
    end else if (cfg[SLOT_PCM_BIT]) begin
      slot_hit = (rel < 12'h100) && msk[rel[7:3]];
    end else begin
      slot_hit = rel <= {3'h0, cfg[8:0]};
    end
  endfunction

  assign setup       = psel_in && !penable_in;
  assign wr          = psel_in && penable_in && pwrite_in;
  assign rd          = psel_in && penable_in && !pwrite_in;
  assign mode5       = st.ctrl[2:0] == CLOCK_MODE_PCM;
  assign tm_internal = st.timer_cfg[TM_MODE_BIT] && st.ctrl[CTRL_AUTO_BIT];
  assign sti_wr      = wr && (paddr_in == CMD_OFF) && pwdata_in[CMD_STI_BIT];
  assign zero_wr     = wr && (paddr_in == TIMER_OFF) &&
                       (pwdata_in[23:0] == 24'h000000);
  assign tx_start    = slot_start(st.tx_assign);
  assign rx_start    = slot_start(st.rx_assign);
  assign baud_k      = {15'h0000, st.baud[5:0]} << st.baud[BAUD_M_LSB+:4];

  // pin edges are taken once the second and third stages agree
  assign txclk_rise = (st.s_txclk[1] == st.s_txclk[2]) && st.s_txclk[2] &&
                      !st.f_txclk;
  assign fs_rise    = (st.s_fsync[1] == st.s_fsync[2]) && st.s_fsync[2] &&
                      !st.f_fsync;
  assign rxd_now    = (st.s_rxd[1] == st.s_rxd[2]) ? st.s_rxd[2] : st.f_rxd;

  always_comb begin
    logic        tick;
    logic        start_req;
    logic        stop_req;
    logic [11:0] pos_n;
    logic        hit;
    logic [1:0]  events;
    logic [1:0]  clr;
    next_st   = st;
    tick      = 1'b0;
    start_req = 1'b0;
    stop_req  = 1'b0;
    pos_n     = st.pos;
    hit       = 1'b0;
    events    = 2'b00;
    clr       = 2'b00;

    // input synchronisers and filtered levels
    next_st.s_txclk = {st.s_txclk[1:0], tx_clk_pin_in};
    next_st.s_fsync = {st.s_fsync[1:0], frame_sync_input_in};
    next_st.s_rxd   = {st.s_rxd[1:0], rx_data_pin_in};
    if (st.s_txclk[1] == st.s_txclk[2]) begin
      next_st.f_txclk = st.s_txclk[2];
    end
    if (st.s_fsync[1] == st.s_fsync[2]) begin
      next_st.f_fsync = st.s_fsync[2];
    end
    next_st.f_rxd = rxd_now;

    // apb read data latched in the setup cycle
    if (setup) begin
      case (paddr_in)
        INT_STAT_OFF: next_st.prdata = {30'h0, st.int_status};
        INT_MASK_OFF: next_st.prdata = {30'h0, st.int_mask};
        CTRL_OFF:     next_st.prdata = {26'h0, st.ctrl};
        ESC_OFF:      next_st.prdata = st.esc_chars;
        TX_SLOT_OFF:  next_st.prdata = st.tx_assign;
        RX_SLOT_OFF:  next_st.prdata = st.rx_assign;
        TX_MASK_OFF:  next_st.prdata = st.tx_mask;
        RX_MASK_OFF:  next_st.prdata = st.rx_mask;
        BAUD_OFF:     next_st.prdata = st.baud;
        TIMER_OFF:    next_st.prdata = st.timer_cfg;
        default:      next_st.prdata = 32'h0000_0000;
      endcase
    end

    // register writes at the access edge
    if (wr) begin
      case (paddr_in)
        INT_MASK_OFF: next_st.int_mask  = pwdata_in[1:0];
        CTRL_OFF:     next_st.ctrl      = pwdata_in[5:0] & CTRL_WMASK;
        ESC_OFF:      next_st.esc_chars = pwdata_in;
        TX_SLOT_OFF:  next_st.tx_assign = pwdata_in & SLOT_WMASK;
        RX_SLOT_OFF:  next_st.rx_assign = pwdata_in & SLOT_WMASK;
        TX_MASK_OFF:  next_st.tx_mask   = pwdata_in;
        RX_MASK_OFF:  next_st.rx_mask   = pwdata_in;
        BAUD_OFF:     next_st.baud      = pwdata_in & BAUD_WMASK;
        TIMER_OFF:    next_st.timer_cfg = pwdata_in & TIMER_WMASK;
        default:      next_st.ctrl      = st.ctrl;
      endcase
    end

    // escape decision for each offered character
    next_st.esc_valid = tx_char_valid_in;
    next_st.esc_flag  = 1'b0;
    if (tx_char_valid_in && st.ctrl[CTRL_PPP_BIT]) begin
      if (tx_char_in == FLAG_CHAR) begin
        next_st.esc_flag = 1'b1;
      end
      for (int i = 0; i < 4; i++) begin
        if (tx_char_in == st.esc_chars[8*i+:8]) begin
          next_st.esc_flag = 1'b1;
        end
      end
    end

    // bit position since frame sync, slot gating per bit
    next_st.tx_req   = 1'b0;
    next_st.rx_valid = 1'b0;
    if (txclk_rise) begin
      if (fs_rise) begin
        pos_n = 12'h000;
      end else if (st.pos == POS_MAX) begin
        pos_n = 12'h000; // first tick after frame sync is bit zero
      end else if (st.pos != POS_MAX - 12'h001) begin
        pos_n = st.pos + 12'h001;
      end
      next_st.pos = pos_n;
      hit = mode5 ? slot_hit(pos_n, st.tx_assign, st.tx_mask) : 1'b1;
      next_st.tx_act  = hit;
      next_st.tx_oe_b = !hit;
      next_st.tx_req  = hit;
      if (hit) begin
        next_st.tx_data = tx_bit_in;
      end
      hit = mode5 ? slot_hit(pos_n, st.rx_assign, st.rx_mask) : 1'b1;
      next_st.rx_act   = hit;
      next_st.rx_valid = hit;
      if (hit) begin
        next_st.rx_bit = rxd_now;
      end
    end else if (fs_rise) begin
      next_st.pos = POS_MAX; // sync seen, waiting for bit zero
    end

    // baud generator on the system clock
    next_st.baud_tick = 1'b0;
    // counts 0 to k-1; k itself may not fit the counter
    if (st.baud_cnt >= baud_k +
        ((21'h000001 << st.baud[BAUD_M_LSB+:4]) - 21'h000001)) begin
      next_st.baud_cnt  = 21'h000000;
      next_st.baud_tick = 1'b1;
    end else begin
      next_st.baud_cnt = st.baud_cnt + 21'h000001;
    end

    // timer clock source
    if (st.timer_cfg[TM_SRC_BIT] && mode5) begin
      tick = fs_rise;
    end else begin
      tick = txclk_rise;
    end
    if (tm_internal) begin
      start_req = proto_timer_start_in;
      stop_req  = proto_timer_stop_in;
    end else begin
      start_req = sti_wr;
      stop_req  = zero_wr;
    end

    next_st.tm_timeout = 1'b0;
    case (st.tm_state)
      TM_IDLE: begin
        if (start_req) begin
          next_st.tm_state    = TM_RUN;
          next_st.tm_count    = st.timer_cfg[23:0];
          next_st.tm_restarts = st.timer_cfg[TM_CNT_LSB+:3];
        end
      end
      TM_RUN: begin
        if (start_req) begin
          next_st.tm_count    = st.timer_cfg[23:0];
          next_st.tm_restarts = st.timer_cfg[TM_CNT_LSB+:3];
        end else if (stop_req) begin
          next_st.tm_state = TM_IDLE;
        end else if (tick) begin
          if (st.tm_count != 24'h000000) begin
            next_st.tm_count = st.tm_count - 24'h000001;
          end else begin
            next_st.tm_timeout = 1'b1;
            events[INT_TM_BIT] = 1'b1;
            next_st.tm_count   = st.timer_cfg[23:0];
            if (st.timer_cfg[TM_CNT_LSB+:3] == CNT_PERIODIC) begin
              next_st.tm_state = TM_RUN;
            end else if (st.tm_restarts != 3'h0) begin
              next_st.tm_restarts = st.tm_restarts - 3'h1;
            end else begin
              next_st.tm_state = TM_IDLE;
            end
          end
        end
      end
      default: next_st.tm_state = TM_IDLE;
    endcase

    // sticky status, read clears only what was reported, set wins
    events[INT_FS_BIT] = fs_rise;
    if (rd && (paddr_in == INT_STAT_OFF)) begin
      clr = st.prdata[1:0];
    end
    next_st.int_status = (st.int_status & ~clr) | events;

    if (!rst_b_in) begin
      next_st           = '0;
      next_st.esc_chars = ESC_RESET;
      next_st.tx_oe_b   = 1'b1;
      next_st.tm_state  = TM_IDLE;
    end
  end

  always_ff @(posedge clk_in) begin
    st <= next_st;
  end

  assign prdata_out       = st.prdata;
  assign pready_out       = 1'b1;
  assign pslverr_out      = psel_in && penable_in && !addr_mapped(paddr_in);
  assign irq_out          = |(st.int_status & st.int_mask);
  assign tx_data_out      = st.tx_data;
  assign tx_data_oe_b_out = st.tx_oe_b;
  assign tx_bit_req_out   = st.tx_req;
  assign rx_bit_out       = st.rx_bit;
  assign rx_bit_valid_out = st.rx_valid;
  assign esc_valid_out    = st.esc_valid;
  assign esc_flag_out     = st.esc_flag;
  assign timer_timeout_out = st.tm_timeout;
  assign timer_running_out = st.tm_state == TM_RUN;
  assign baud_tick_out    = st.baud_tick;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  a_esc_flag_char: assert property (
    tx_char_valid_in && st.ctrl[CTRL_PPP_BIT] && tx_char_in == FLAG_CHAR
    |=> esc_valid_out && esc_flag_out)
    else $error("flag character not escaped");

  a_esc_user_char: assert property (
    tx_char_valid_in && st.ctrl[CTRL_PPP_BIT] &&
    tx_char_in == st.esc_chars[31:24] |=> esc_flag_out)
    else $error("user character not escaped");

  a_slot_mode_gate: assert property (
    txclk_rise && !mode5 |=> st.tx_act && st.rx_act && !tx_data_oe_b_out)
    else $error("slot gating outside clock mode 5");

  a_tx_slot_first: assert property (
    txclk_rise && !fs_rise && mode5 && !st.tx_assign[SLOT_PCM_BIT] &&
    st.pos + 12'h001 == tx_start |=> st.tx_act && tx_bit_req_out)
    else $error("transmit slot does not open at its first bit");

  a_tx_slot_width: assert property (
    txclk_rise && !fs_rise && mode5 && !st.tx_assign[SLOT_PCM_BIT] &&
    st.pos == tx_start + {3'h0, st.tx_assign[8:0]} |=> !st.tx_act)
    else $error("transmit slot wider than capacity plus one");

  a_rx_slot_width: assert property (
    txclk_rise && !fs_rise && mode5 && !st.rx_assign[SLOT_PCM_BIT] &&
    st.pos == rx_start + {3'h0, st.rx_assign[8:0]} |=> !rx_bit_valid_out)
    else $error("receive slot wider than capacity plus one");

  a_tx_mask_slot0: assert property (
    txclk_rise && !fs_rise && mode5 && st.tx_assign[SLOT_PCM_BIT] &&
    st.pos + 12'h001 == tx_start |=> st.tx_act == $past(st.tx_mask[0]))
    else $error("transmit mask slot zero misplaced");

  a_rx_mask_slot1: assert property (
    txclk_rise && !fs_rise && mode5 && st.rx_assign[SLOT_PCM_BIT] &&
    st.pos + 12'h001 == rx_start + 12'h008
    |=> rx_bit_valid_out == $past(st.rx_mask[1]))
    else $error("receive mask slot one misplaced");

  a_tx_quiet_drive: assert property (
    txclk_rise |=> tx_data_oe_b_out == !st.tx_act &&
    (!st.tx_act || tx_data_out == $past(tx_bit_in)))
    else $error("transmit pin driven outside an active slot");

  a_baud_div_two: assert property (
    baud_tick_out && st.baud == 32'h0000_0001 && !wr
    |=> !baud_tick_out ##1 baud_tick_out)
    else $error("baud divider by two wrong");

  a_timer_start: assert property (
    sti_wr && !tm_internal |=> timer_running_out &&
    st.tm_count == $past(st.timer_cfg[23:0]))
    else $error("timer did not start with its value");

  a_timer_zero_stop: assert property (
    zero_wr && !tm_internal && !sti_wr |=> !timer_running_out)
    else $error("zero value write did not halt timer");

  a_timer_last_exp: assert property (
    timer_running_out && txclk_rise && !st.timer_cfg[TM_SRC_BIT] &&
    st.tm_count == 24'h000000 && st.tm_restarts == 3'h0 &&
    st.timer_cfg[TM_CNT_LSB+:3] != CNT_PERIODIC && !sti_wr && !zero_wr &&
    !tm_internal |=> !timer_running_out && timer_timeout_out &&
    st.int_status[INT_TM_BIT])
    else $error("timer did not stop and interrupt on last expiry");

endmodule

// ==== tb/scc_line_model.sv ====
// highway model: bit clock, frame sync and receive data of the far side
`timescale 1ns/10ps
module scc_line_model (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  // highway pins
  output logic      tx_clk_out,
  output logic      fsync_out,
  output logic      rxd_out
);
  logic [2:0] div;
  logic [5:0] bitc;
  // bit clock of eight system clocks, 64-bit frame
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      div  <= 3'h0;
      bitc <= 6'h0;
    end else begin
      div <= div + 3'h1;
      if (div == 3'h7) begin
        bitc <= bitc + 6'h1;
      end
    end
  end
  assign tx_clk_out = rst_b_in & div[2];
  assign fsync_out  = rst_b_in & (bitc == 6'h0);
  // data changes every bit except every eighth, where bitc[3] toggles too
  assign rxd_out    = bitc[0] ^ bitc[3] ^ ~rst_b_in;
endmodule

// ==== tb/testbench.sv ====
// self-checking bench of the slot, baud and timer block
`timescale 1ns/10ps
module testbench;
  import scc_pkg::*;
  logic        clk_in, rst_b_in, psel, pen, pwr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, irq, txc, fs, rxd, txd, txoe_b, txbit;
  logic        req, rxb, rxv, cval, escv, escf, tmo, trun, btick;
  logic        pstart, pstop;
  logic [7:0]  chr;
  int          n_mismatch, tests_run;

  scc_slot_baud_timer_cfg u_scc_slot_baud_timer_cfg (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .irq_out(irq), .tx_clk_pin_in(txc),
    .frame_sync_input_in(fs), .rx_data_pin_in(rxd), .tx_data_out(txd),
    .tx_data_oe_b_out(txoe_b), .tx_bit_in(txbit), .tx_bit_req_out(req),
    .rx_bit_out(rxb), .rx_bit_valid_out(rxv), .tx_char_valid_in(cval),
    .tx_char_in(chr), .esc_valid_out(escv), .esc_flag_out(escf),
    .proto_timer_start_in(pstart), .proto_timer_stop_in(pstop),
    .timer_timeout_out(tmo), .timer_running_out(trun),
    .baud_tick_out(btick));

  scc_line_model u_scc_line_model (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .tx_clk_out(txc),
    .fsync_out(fs), .rxd_out(rxd));

  task automatic close_out();
    $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      n_mismatch++;
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int i;
    @(posedge clk_in);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_in);
      i++;
    end while (pready !== 1'b1 && i < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    if (i >= 50) begin
      n_mismatch++;
      close_out();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  // cycles until baud tick (s=0) or timeout (s=1)
  task automatic wait_hi(input int s, output int c);
    c = 0;
    do begin
      @(negedge clk_in);
      c++;
    end while (((s == 0) ? btick : tmo) !== 1'b1 && c < 2000);
    if (c >= 2000) begin
      n_mismatch++;
      close_out();
    end
  endtask

  task automatic count_tmo(input int len, output int n);
    n = 0;
    repeat (len) begin
      @(negedge clk_in);
      if (tmo === 1'b1) n++;
    end
  endtask

  task automatic fs_rise();
    int c;
    c = 0;
    do begin
      @(negedge clk_in);
      c++;
    end while (!(fs === 1'b1 && u_scc_line_model.bitc == 6'h0 &&
                 u_scc_line_model.div == 3'h1) && c < 2000);
    if (c >= 2000) begin
      n_mismatch++;
      close_out();
    end
  endtask

  task automatic t_reset();
    logic [31:0] q;
    logic        e;
    for (int i = 0; i < 7; i++) begin
      rd(ESC_OFF + 12'(4 * i), q);
      chk(q, (i == 0) ? ESC_RESET : 32'h0);
    end
    apb(1'b0, 12'h200, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    wr(TX_SLOT_OFF, 32'hFFFF_FFFF);
    rd(TX_SLOT_OFF, q);
    chk(q, SLOT_WMASK);
    wr(TX_SLOT_OFF, 32'h0);
  endtask

  task automatic esc_case(input logic [7:0] c, input logic f);
    @(posedge clk_in);
    cval <= 1'b1;
    chr  <= c;
    @(posedge clk_in);
    cval <= 1'b0;
    @(negedge clk_in);
    chk({31'h0, escv}, 32'h1);
    chk({31'h0, escf}, {31'h0, f});
  endtask

  task automatic t_escape();
    wr(CTRL_OFF, 32'h10);
    esc_case(8'h55, 1'b0);
    esc_case(8'h7E, 1'b1);
    wr(ESC_OFF, 32'h41FF_0011);
    esc_case(8'h00, 1'b1);
    esc_case(8'hFF, 1'b1);
    esc_case(8'h41, 1'b1);
    esc_case(8'h7E, 1'b1);
    esc_case(8'h55, 1'b0);
  endtask

  task automatic baud_case(input logic [31:0] v, input int k);
    int c;
    wr(BAUD_OFF, v);
    wait_hi(0, c);
    wait_hi(0, c);
    chk(c, k);
  endtask

  // tx requests and rx bits counted over one full frame
  task automatic slot_case(input logic [31:0] ctl, ta, ra, tm, rm,
                           input int et, input int er);
    int nt;
    int nr;
    logic [5:0] b;
    wr(CTRL_OFF, ctl);
    wr(TX_SLOT_OFF, ta);
    wr(RX_SLOT_OFF, ra);
    wr(TX_MASK_OFF, tm);
    wr(RX_MASK_OFF, rm);
    fs_rise();
    nt = 0;
    nr = 0;
    for (int i = 0; i < 512; i++) begin
      @(negedge clk_in);
      if (req === 1'b1) begin
        nt++;
        chk({31'h0, txd}, {31'h0, ~txbit});
      end
      if (rxv === 1'b1) begin
        nr++;
        b = u_scc_line_model.bitc - 6'h1;
        chk({31'h0, rxb}, {31'h0, b[0] ^ b[3]});
      end
    end
    chk(nt, et);
    chk(nr, er);
  endtask

  task automatic t_period(input logic [31:0] ctl, cfg, input int k);
    int c;
    wr(CTRL_OFF, ctl);
    wr(TIMER_OFF, cfg);
    wr(CMD_OFF, 32'h1);
    wait_hi(1, c);
    wait_hi(1, c);
    chk(c, k);
    wr(TIMER_OFF, 32'h0700_0000);
    count_tmo(600, c);
    chk(c, 0);
    chk({31'h0, trun}, 32'h0);
  endtask

  task automatic t_restart();
    int          n;
    logic [31:0] q;
    wr(INT_MASK_OFF, 32'h1);
    rd(INT_STAT_OFF, q);
    wr(TIMER_OFF, 32'h0200_0000);
    wr(CMD_OFF, 32'h1);
    count_tmo(200, n);
    chk(n, 3);
    chk({31'h0, trun}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    wr(INT_MASK_OFF, 32'h0);
    @(negedge clk_in);
    chk({31'h0, irq}, 32'h0);
    wr(INT_MASK_OFF, 32'h1);
    rd(INT_STAT_OFF, q);
    chk(q & 32'h1, 32'h1);
    @(negedge clk_in);
    chk({31'h0, irq}, 32'h0);
  endtask

  // internal mode: protocol pulses run the timer, the command does not
  task automatic t_internal();
    wr(CTRL_OFF, 32'h20);
    wr(TIMER_OFF, 32'h1000_0003);
    wr(CMD_OFF, 32'h1);
    @(negedge clk_in);
    chk({31'h0, trun}, 32'h0);
    @(posedge clk_in);
    pstart <= 1'b1;
    @(posedge clk_in);
    pstart <= 1'b0;
    @(negedge clk_in);
    chk({31'h0, trun}, 32'h1);
    @(posedge clk_in);
    pstop <= 1'b1;
    @(posedge clk_in);
    pstop <= 1'b0;
    @(negedge clk_in);
    chk({31'h0, trun}, 32'h0);
  endtask

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) txbit <= ~txbit;

  initial begin
    n_mismatch = 0;
    tests_run  = 0;
    rst_b_in   = 1'b0;
    {psel, pen, pwr, cval, txbit, pstart, pstop} = 7'h00;
    paddr  = 12'h0;
    pwdata = 32'h0;
    chr    = 8'h0;
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    t_reset();
    t_escape();
    baud_case(32'h0000_0042, 6);
    baud_case(32'h0000_0084, 20);
    baud_case(32'h0000_0001, 2);
    slot_case(32'h0, 32'h0102_0003, 32'h0, 0, 0, 64, 64);
    slot_case(32'h5, 32'h0102_0003, 32'h0200_0006, 0, 0, 4, 7);
    slot_case(32'h5, 32'h0000_8000, 32'h0100_8000, 5, 1, 16, 8);
    t_restart();
    t_period(32'h0, 32'h0700_0004, 40);
    t_period(32'h5, 32'h8700_0000, 512);
    t_internal();
    close_out();
  end
endmodule
